// ---- pkg/fpdc_pkg.sv ----
package fpdc_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_ALARM_FILTER = 8'h4B;
  localparam logic [7:0] ADDR_DEVICE_SETUP = 8'h4C;
  localparam logic [7:0] ADDR_IO_SETUP = 8'h4D;

  // ---------------------------------------------------------------
  // Reset values and writable bits
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_ALARM_FILTER = 16'h0780;
  localparam logic [15:0] RST_DEVICE_SETUP = 16'h0000;
  localparam logic [15:0] RST_IO_SETUP = 16'h0000;
  localparam logic [15:0] WMASK_ALARM_FILTER = 16'h7F80;
  localparam logic [15:0] WMASK_DEVICE_SETUP = 16'h7B00;
  localparam logic [15:0] WMASK_IO_SETUP = 16'h7FFD;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int FLT_MSB = 14;
  localparam int FLT_LSB = 7;
  localparam int DS_DONE_OWNER = 14;
  localparam int DS_TIMEBASE = 12;
  localparam int DS_WORD_LEN = 11;
  localparam int DS_PWR_MSB = 9;
  localparam int DS_PWR_LSB = 8;
  localparam int IO_FMT_MSB = 14;
  localparam int IO_FMT_LSB = 10;
  localparam int IO_DIR_MSB = 9;
  localparam int IO_DIR_LSB = 5;
  localparam int IO_SRC_MSB = 4;
  localparam int IO_SRC_LSB = 2;
  localparam int IO_SRC0 = 0;

  // ---------------------------------------------------------------
  // Frame word widths
  // ---------------------------------------------------------------
  localparam logic [5:0] WORD_BITS_SHORT = 6'h18;
  localparam logic [5:0] WORD_BITS_LONG = 6'h20;

  // ---------------------------------------------------------------
  // Power states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_STANDBY,
    PWR_DOWN_A,
    PWR_DOWN_B
  } fpdc_pwr_t;

  // Summary flags, active high, bit order matches the filter field
  typedef struct packed {
    logic powerRail;
    logic timebase;
    logic logicIntegrity;
    logic overcurrent;
    logic serialChecksum;
    logic serialTimeout;
    logic serialClockCount;
    logic illegalAccess;
  } fpdc_flags_t;

  // Per-pin io settings
  typedef struct packed {
    logic [4:0] formatPwm;
    logic [4:0] directionOut;
    logic [4:0] source;
  } fpdc_io_t;

endpackage

// ---- src/fpdc_regs.sv ----
`timescale 1ns/1ns
module fpdc_regs (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [15:0] regRdData,
  output logic regRdValid,
  input wire fpdc_pkg::fpdc_flags_t flags,
  input wire logic io2AlarmMode,
  output logic alarmOut,
  output logic alarmOe,
  output logic doneOwnerSecond,
  output logic timebaseExternal,
  output logic [5:0] frameWordBits,
  input wire logic [23:0] sampleWord,
  output logic [31:0] frameWord,
  output fpdc_pkg::fpdc_pwr_t powerState,
  output logic convertersEnabled,
  output logic powerDown,
  output fpdc_pkg::fpdc_io_t ioSetup,
  output logic [4:0] ioPulseWidthMode
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [15:0] merge_write(input logic [15:0] cur,
                                              input logic [15:0] wr,
                                              input logic [15:0] msk);
    merge_write = (cur & ~msk) | (wr & msk);
  endfunction

  function automatic logic [31:0] pad_word(input logic [23:0] w,
                                           input logic longWord);
    pad_word = longWord ? {w, 8'h00} : {8'h00, w};
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [15:0] alarmFilter;
  logic [15:0] deviceSetup;
  logic [15:0] ioSetupReg;

  wire hitFilter = regAddr == fpdc_pkg::ADDR_ALARM_FILTER;
  wire hitSetup = regAddr == fpdc_pkg::ADDR_DEVICE_SETUP;
  wire hitIo = regAddr == fpdc_pkg::ADDR_IO_SETUP;

  // Only writable bits ever change; the rest hold their reset zero
  wire [15:0] next_alarmFilter =
    merge_write(alarmFilter, regWrData, fpdc_pkg::WMASK_ALARM_FILTER);
  wire [15:0] next_deviceSetup =
    merge_write(deviceSetup, regWrData, fpdc_pkg::WMASK_DEVICE_SETUP);
  wire [15:0] next_ioSetup =
    merge_write(ioSetupReg, regWrData, fpdc_pkg::WMASK_IO_SETUP);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      alarmFilter <= fpdc_pkg::RST_ALARM_FILTER;
      deviceSetup <= fpdc_pkg::RST_DEVICE_SETUP;
      ioSetupReg <= fpdc_pkg::RST_IO_SETUP;
    end else if (regWrEn) begin
      if (hitFilter) begin
        alarmFilter <= next_alarmFilter;
      end else if (hitSetup) begin
        deviceSetup <= next_deviceSetup;
      end else if (hitIo) begin
        ioSetupReg <= next_ioSetup;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  wire [15:0] rdMux =
    hitFilter ? (alarmFilter & fpdc_pkg::WMASK_ALARM_FILTER) :
    hitSetup ? (deviceSetup & fpdc_pkg::WMASK_DEVICE_SETUP) :
    hitIo ? (ioSetupReg & fpdc_pkg::WMASK_IO_SETUP) :
    16'h0000;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      regRdData <= 16'h0000;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        regRdData <= rdMux;
      end
    end
  end

  // ---------------------------------------------------------------
  // Alarm pin
  // ---------------------------------------------------------------
  wire [7:0] filterMask = alarmFilter[fpdc_pkg::FLT_MSB:fpdc_pkg::FLT_LSB];
  wire [7:0] passFlags = flags & ~filterMask;
  wire next_alarmOut = io2AlarmMode & (|passFlags);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      alarmOut <= 1'b0;
      alarmOe <= 1'b0;
    end else begin
      alarmOut <= next_alarmOut;
      alarmOe <= io2AlarmMode;
    end
  end

  // ---------------------------------------------------------------
  // Device setup decode
  // ---------------------------------------------------------------
  wire longWord = deviceSetup[fpdc_pkg::DS_WORD_LEN];
  wire [1:0] pwrSel = deviceSetup[fpdc_pkg::DS_PWR_MSB:fpdc_pkg::DS_PWR_LSB];

  // Timebase switching is only safe while converters are idle; the host
  // guarantees that and keeps the external clock until switch-over.
  assign doneOwnerSecond = deviceSetup[fpdc_pkg::DS_DONE_OWNER];
  assign timebaseExternal = deviceSetup[fpdc_pkg::DS_TIMEBASE];
  assign frameWordBits = longWord ? fpdc_pkg::WORD_BITS_LONG :
                                    fpdc_pkg::WORD_BITS_SHORT;
  assign powerState = fpdc_pkg::fpdc_pwr_t'(pwrSel);
  assign convertersEnabled = powerState == fpdc_pkg::PWR_ACTIVE;
  assign powerDown = pwrSel[1];

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      frameWord <= 32'h00000000;
    end else begin
      frameWord <= pad_word(sampleWord, longWord);
    end
  end

  // ---------------------------------------------------------------
  // Io setup decode
  // ---------------------------------------------------------------
  assign ioSetup.formatPwm = ioSetupReg[fpdc_pkg::IO_FMT_MSB:fpdc_pkg::IO_FMT_LSB];
  assign ioSetup.directionOut = ioSetupReg[fpdc_pkg::IO_DIR_MSB:fpdc_pkg::IO_DIR_LSB];
  assign ioSetup.source = {ioSetupReg[fpdc_pkg::IO_SRC_MSB:fpdc_pkg::IO_SRC_LSB],
                           1'b0, ioSetupReg[fpdc_pkg::IO_SRC0]};
  // Same selection drives input decoding and output generation
  assign ioPulseWidthMode = ioSetup.formatPwm;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  AST_ALARM_BLOCKED_OUTSIDE_MODE: assert property (
    !io2AlarmMode |=> !alarmOut)
    else $error("alarm active while io2 not in alarm mode");

  AST_POWER_RAIL_PASS: assert property (
    io2AlarmMode && flags.powerRail && !alarmFilter[14] |=> alarmOut)
    else $error("unmasked power rail flag missed");

  AST_TIMEBASE_BLOCK: assert property (
    io2AlarmMode && flags == 8'h40 && alarmFilter[13] |=> !alarmOut)
    else $error("masked timebase flag reached alarm");

  AST_CHECKSUM_RESET_MASKED: assert property (
    $rose(rstn) |-> alarmFilter == 16'h0780)
    else $error("filter reset value wrong");

  AST_FILTER_RESERVED_ZERO: assert property (
    regRdValid && $past(hitFilter) |-> (regRdData & 16'h807F) == 16'h0000)
    else $error("filter reserved bits read nonzero");

  AST_SETUP_RESERVED_ZERO: assert property (
    regRdValid && $past(hitSetup) |-> (regRdData & 16'h84FF) == 16'h0000)
    else $error("setup reserved bits read nonzero");

  AST_IO_RESERVED_ZERO: assert property (
    regRdValid && $past(hitIo) |-> (regRdData & 16'h8002) == 16'h0000)
    else $error("io reserved bits read nonzero");

  AST_STANDBY_DISABLES: assert property (
    pwrSel != 2'b00 |-> !convertersEnabled)
    else $error("converters enabled outside active mode");

  AST_WORD_PAD: assert property (
    longWord && $stable(longWord) |=> frameWord == {$past(sampleWord), 8'h00})
    else $error("long word not zero padded");

  AST_DONE_OWNER_WRITE: assert property (
    regWrEn && hitSetup |=> doneOwnerSecond == $past(regWrData[14]))
    else $error("done owner select not written");

  AST_ALARM_ANY_FLAG: assert property (
    io2AlarmMode && (|(flags & ~filterMask)) |=> alarmOut)
    else $error("unmasked flag did not raise alarm");

  AST_POWER_RAIL_BLOCK: assert property (
    io2AlarmMode && flags == 8'h80 && alarmFilter[14] |=> !alarmOut)
    else $error("masked power rail flag reached alarm");

  AST_TIMEBASE_PASS: assert property (
    io2AlarmMode && flags.timebase && !alarmFilter[13] |=> alarmOut)
    else $error("unmasked timebase flag missed");

  AST_LOGIC_PASS: assert property (
    io2AlarmMode && flags.logicIntegrity && !alarmFilter[12] |=> alarmOut)
    else $error("unmasked logic integrity flag missed");

  AST_LOGIC_BLOCK: assert property (
    io2AlarmMode && flags == 8'h20 && alarmFilter[12] |=> !alarmOut)
    else $error("masked logic integrity flag reached alarm");

  AST_OVERCURRENT_PASS: assert property (
    io2AlarmMode && flags.overcurrent && !alarmFilter[11] |=> alarmOut)
    else $error("unmasked overcurrent flag missed");

  AST_OVERCURRENT_BLOCK: assert property (
    io2AlarmMode && flags == 8'h10 && alarmFilter[11] |=> !alarmOut)
    else $error("masked overcurrent flag reached alarm");

  AST_CHECKSUM_PASS: assert property (
    io2AlarmMode && flags.serialChecksum && !alarmFilter[10] |=> alarmOut)
    else $error("unmasked checksum flag missed");

  AST_CHECKSUM_BLOCK: assert property (
    io2AlarmMode && flags == 8'h08 && alarmFilter[10] |=> !alarmOut)
    else $error("masked checksum flag reached alarm");

  AST_TIMEOUT_PASS: assert property (
    io2AlarmMode && flags.serialTimeout && !alarmFilter[9] |=> alarmOut)
    else $error("unmasked timeout flag missed");

  AST_TIMEOUT_BLOCK: assert property (
    io2AlarmMode && flags == 8'h04 && alarmFilter[9] |=> !alarmOut)
    else $error("masked timeout flag reached alarm");

  AST_CLOCK_COUNT_PASS: assert property (
    io2AlarmMode && flags.serialClockCount && !alarmFilter[8] |=> alarmOut)
    else $error("unmasked clock count flag missed");

  AST_CLOCK_COUNT_BLOCK: assert property (
    io2AlarmMode && flags == 8'h02 && alarmFilter[8] |=> !alarmOut)
    else $error("masked clock count flag reached alarm");

  AST_ACCESS_PASS: assert property (
    io2AlarmMode && flags.illegalAccess && !alarmFilter[7] |=> alarmOut)
    else $error("unmasked access flag missed");

  AST_ACCESS_BLOCK: assert property (
    io2AlarmMode && flags == 8'h01 && alarmFilter[7] |=> !alarmOut)
    else $error("masked access flag reached alarm");

  AST_OE_ON_IN_MODE: assert property (
    io2AlarmMode |=> alarmOe)
    else $error("alarm drive off in alarm mode");

  AST_OE_OFF_OUT_MODE: assert property (
    !io2AlarmMode |=> !alarmOe)
    else $error("alarm drive on outside alarm mode");

  AST_ALARM_QUIET_ALL_MASKED: assert property (
    io2AlarmMode && !(|(flags & ~filterMask)) |=> !alarmOut)
    else $error("alarm raised with every flag masked");

  AST_FILTER_STORE_RESERVED: assert property (
    (alarmFilter & 16'h807F) == 16'h0000)
    else $error("filter reserved bits stored");

  AST_SETUP_STORE_RESERVED: assert property (
    (deviceSetup & 16'h84FF) == 16'h0000)
    else $error("setup reserved bits stored");

  AST_IO_STORE_RESERVED: assert property (
    (ioSetupReg & 16'h8002) == 16'h0000)
    else $error("io reserved bits stored");

  AST_FILTER_WRITE: assert property (
    regWrEn && hitFilter |=> alarmFilter[14:7] == $past(regWrData[14:7]))
    else $error("filter mask bits not written");

  AST_TIMEBASE_WRITE: assert property (
    regWrEn && hitSetup |=> timebaseExternal == $past(regWrData[12]))
    else $error("timebase select not written");

  AST_TIMEBASE_HOLD: assert property (
    !(regWrEn && hitSetup) |=> $stable(timebaseExternal))
    else $error("timebase select changed without write");

  AST_DONE_OWNER_HOLD: assert property (
    !(regWrEn && hitSetup) |=> $stable(doneOwnerSecond))
    else $error("done owner changed without write");

  AST_WORD_LEN_WRITE: assert property (
    regWrEn && hitSetup |=> (frameWordBits == 6'h20) == $past(regWrData[11]))
    else $error("word length not written");

  AST_SHORT_WORD_ALIGN: assert property (
    !longWord && $stable(longWord) |=> frameWord == {8'h00, $past(sampleWord)})
    else $error("short word not right aligned");

  AST_POWER_DOWN_DECODE: assert property (
    powerDown == (pwrSel >= 2'b10))
    else $error("power down decode wrong");

  AST_ACTIVE_ENABLES: assert property (
    pwrSel == 2'b00 |-> convertersEnabled)
    else $error("converters disabled in active mode");

  AST_IO_FORMAT_WRITE: assert property (
    regWrEn && hitIo |=> ioSetup.formatPwm == $past(regWrData[14:10]))
    else $error("io format bits not written");

  AST_IO_DIR_WRITE: assert property (
    regWrEn && hitIo |=> ioSetup.directionOut == $past(regWrData[9:5]))
    else $error("io direction bits not written");

  COV_ALARM_RAISED: cover property (io2AlarmMode ##1 alarmOut);
  COV_LONG_WORD: cover property (regWrEn && hitSetup && regWrData[11]);
  COV_POWER_DOWN: cover property (powerDown);
  COV_IO_READ: cover property (regRdEn && hitIo ##1 regRdValid);
  COV_ALARM_MASKED: cover property (io2AlarmMode && (|flags) && !(|passFlags));

endmodule

// ---- tb/fpdc_host.sv ----
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Host model of the register port and flag sources
// ---------------------------------------------------------------
module fpdc_host (
  input wire logic clk_sys,
  input wire logic [15:0] regRdData,
  input wire logic regRdValid,
  output logic [7:0] regAddr,
  output logic [15:0] regWrData,
  output logic regWrEn,
  output logic regRdEn,
  output fpdc_pkg::fpdc_flags_t flags,
  output logic io2AlarmMode,
  output logic [23:0] sampleWord
);
  initial begin
    regAddr = 8'h00;
    regWrData = 16'h0000;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    flags = fpdc_pkg::fpdc_flags_t'(8'h00);
    io2AlarmMode = 1'b0;
    sampleWord = 24'hA5C31E;
  end
  // Write strobe held for one taking edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    regWrData <= ~d;
  endtask
  // Read with bounded wait for the answer marker
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    for (int k = 0; k < 4 && !ok; k++) begin
      #1;
      if (regRdValid === 1'b1) begin
        d = regRdData;
        ok = 1'b1;
      end else begin
        @(posedge clk_sys);
      end
    end
  endtask
  // Flags and alarm mode, then two edges for the registered alarm
  task automatic drv(input logic [7:0] f, input logic m);
    @(posedge clk_sys);
    flags <= fpdc_pkg::fpdc_flags_t'(f);
    io2AlarmMode <= m;
    @(posedge clk_sys);
    @(posedge clk_sys);
    #1;
  endtask
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  logic clk_sys;
  logic rstn;
  logic [7:0] regAddr;
  logic [15:0] regWrData, regRdData;
  logic regWrEn, regRdEn, regRdValid, io2AlarmMode, alarmOut, alarmOe;
  logic doneOwnerSecond, timebaseExternal, convertersEnabled, powerDown;
  logic [5:0] frameWordBits;
  logic [23:0] sampleWord;
  logic [31:0] frameWord;
  logic [4:0] ioPulseWidthMode;
  fpdc_pkg::fpdc_flags_t flags;
  fpdc_pkg::fpdc_pwr_t powerState;
  fpdc_pkg::fpdc_io_t ioSetup;
  int nErrors = 0;
  int checks = 0;
  fpdc_regs i_fpdc_regs (.clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .flags(flags), .io2AlarmMode(io2AlarmMode),
    .alarmOut(alarmOut), .alarmOe(alarmOe), .doneOwnerSecond(doneOwnerSecond),
    .timebaseExternal(timebaseExternal), .frameWordBits(frameWordBits),
    .sampleWord(sampleWord), .frameWord(frameWord), .powerState(powerState),
    .convertersEnabled(convertersEnabled), .powerDown(powerDown), .ioSetup(ioSetup),
    .ioPulseWidthMode(ioPulseWidthMode));
  fpdc_host i_fpdc_host (.clk_sys(clk_sys), .regRdData(regRdData),
    .regRdValid(regRdValid), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .flags(flags),
    .io2AlarmMode(io2AlarmMode), .sampleWord(sampleWord));
  // ---------------------------------------------------------------
  // Checking and reporting
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("errors %0d checks %0d", nErrors, checks);
    if (nErrors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      nErrors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    i_fpdc_host.rd(a, d, ok);
    if (!ok) begin
      nErrors++;
      close_out();
    end else begin
      chk({16'h0000, d}, {16'h0000, exp});
    end
  endtask
  // ---------------------------------------------------------------
  // Clock, reset and sequence
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    rstn = 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rdchk(8'h4B, 16'h0780);
    rdchk(8'h4C, 16'h0000);
    rdchk(8'h4D, 16'h0000);
    i_fpdc_host.drv(8'h0F, 1'b1);
    chk(alarmOut, 1'b0);
    i_fpdc_host.drv(8'h80, 1'b1);
    chk(alarmOut, 1'b1);
    // Standby first, so the timebase may change
    i_fpdc_host.wr(8'h4C, 16'h0100);
    i_fpdc_host.wr(8'h4C, 16'hFFFF);
    rdchk(8'h4C, 16'h7B00);
    chk({doneOwnerSecond, timebaseExternal, powerDown}, 3'b111);
    chk(frameWordBits, 6'h20);
    chk(frameWord, {sampleWord, 8'h00});
    i_fpdc_host.wr(8'h4B, 16'hFFFF);
    rdchk(8'h4B, 16'h7F80);
    i_fpdc_host.wr(8'h4D, 16'hFFFF);
    rdchk(8'h4D, 16'h7FFD);
    chk(ioSetup, 15'h7FFD);
    chk(ioPulseWidthMode, 5'h1F);
    i_fpdc_host.wr(8'h50, 16'hFFFF);
    rdchk(8'h50, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      i_fpdc_host.wr(8'h4B, 16'h0000);
      i_fpdc_host.drv(8'h01 << i, 1'b1);
      chk(alarmOut, 1'b1);
      i_fpdc_host.wr(8'h4B, 16'h0080 << i);
      i_fpdc_host.drv(8'h01 << i, 1'b1);
      chk(alarmOut, 1'b0);
    end
    i_fpdc_host.wr(8'h4B, 16'h0000);
    i_fpdc_host.drv(8'hFF, 1'b0);
    chk({alarmOut, alarmOe}, 2'b00);
    i_fpdc_host.drv(8'hFF, 1'b1);
    chk({alarmOut, alarmOe}, 2'b11);
    for (int j = 0; j < 4; j++) begin
      i_fpdc_host.wr(8'h4C, 16'(j) << 8);
      @(posedge clk_sys);
      #1;
      chk({convertersEnabled, powerDown}, {j == 0, j >= 2});
      chk(powerState, j);
      chk(timebaseExternal, 1'b0);
      chk(frameWordBits, 6'h18);
      chk(frameWord, {8'h00, sampleWord});
    end
    close_out();
  end
endmodule
